// ---- dpcd_cmd_pipe.sv ----
// Command/address path with zero, one or two added clocks of latency
`timescale 1ns/1ps
`default_nettype none
module dpcd_cmd_pipe #(
   parameter int W = 32
) (
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [1:0]   lat,
   // Command in
   input  wire logic [W-1:0] cmd_i,
   input  wire logic         vld_i,
   // Command out
   output logic [W-1:0]      cmd_o,
   output logic              vld_o
);
   logic [W-1:0] s0_ff, s1_ff, out_ff;
   logic         v0_ff, v1_ff, vo_ff;
   logic [W-1:0] nxt_out;
   logic         nxt_vo;

   // ==========================================
   // Tap select: one base register plus the added clocks
   assign nxt_out = (lat == 2'd0) ? cmd_i : (lat == 2'd1) ? s0_ff : s1_ff;
   assign nxt_vo  = (lat == 2'd0) ? vld_i : (lat == 2'd1) ? v0_ff : v1_ff;

   // Delay stages
   always_ff @(posedge clk) begin
      if (rst) begin
         s0_ff  <= '0;
         s1_ff  <= '0;
         out_ff <= '0;
         v0_ff  <= 1'b0;
         v1_ff  <= 1'b0;
         vo_ff  <= 1'b0;
      end else if (ce) begin
         s0_ff  <= cmd_i;
         s1_ff  <= s0_ff;
         out_ff <= nxt_out;
         v0_ff  <= vld_i;
         v1_ff  <= v0_ff;
         vo_ff  <= nxt_vo;
      end
   end

   assign cmd_o = out_ff;
   assign vld_o = vo_ff;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence lat2_steady;
      (ce && lat == 2'd2)[*4];
   endsequence
   pipe_two_extra_a: assert property ((vld_i && ce && lat == 2'd2) ##0 lat2_steady
                                      |-> vld_o && cmd_o == $past(cmd_i, 3))
      else $error("command not delayed by two added clocks");
   pipe_zero_extra_a: assert property ((ce && lat == 2'd0)[*2] |-> vld_o == $past(vld_i))
      else $error("command delayed without added latency");
endmodule
`default_nettype wire

// ---- dpcd_ctrl_model.sv ----
// Memory controller model issuing commands and column requests
`timescale 1ns/1ps
`default_nettype none
module dpcd_ctrl_model (
   // Clock
   input  wire logic clk,
   // Command and column requests
   output logic [31:0] cmd,
   output logic        vld,
   output logic        wr,
   output logic        rd
);
   initial begin
      cmd = 32'h0;
      vld = 1'b0;
      wr  = 1'b0;
      rd  = 1'b0;
   end

   // One-cycle request; address turns to its inverse when idle so stale values show
   task automatic issue(input logic [31:0] a, input logic v, input logic w, input logic r);
      @(posedge clk);
      cmd <= a;
      vld <= v;
      wr  <= w;
      rd  <= r;
      @(posedge clk);
      cmd <= ~a;
      vld <= 1'b0;
      wr  <= 1'b0;
      rd  <= 1'b0;
      #1;
   endtask
endmodule
`default_nettype wire

// ---- dpcd_pkg.sv ----
// Types shared by the command delay block
package dpcd_pkg;
   typedef enum logic [1:0] {
      DPCD_S_CAL   = 2'b00,
      DPCD_S_RWAIT = 2'b01,
      DPCD_S_CWAIT = 2'b10,
      DPCD_S_RUN   = 2'b11
   } dpcd_init_e;
   typedef logic [1:0]  dpcd_lat_t;
   typedef logic [17:0] dpcd_cnt_t;
endpackage

// ---- dpcd_regs.svh ----
// Register offsets, field positions, reset values and counts of the command delay block
`ifndef DPCD_REGS_SVH
`define DPCD_REGS_SVH
// Overview of operation
// - After calibration finishes, count the reset wait (default 53305, max 0x3ffff) then release DRAM reset.
// - The added command latency delays only the command/address path by zero, one or two clocks.
// - Write and read column requests are never delayed by the added command latency.
// - Internal control scheduling adds the added latency just as a larger CWL or AL would.
// - The added latency is chosen from rank count, error correction and the DRAM latency setup.
// - With AL field 0 and CWL 5 to 7 the setting is 1 single-rank plain, else 2.
// - The complex-pattern stage is skipped or run in full by its flag, full by default.
// - The read reference-voltage stage is skipped by default and runs only when set to full.
// - The write strobe-to-data stage always runs in full.
// - The jitter stage may be reduced only in simulation builds; hardware always uses full.

// ==========================================
// Register byte offsets
`define DPCD_REG_CTRL   12'h000
`define DPCD_REG_LAT    12'h004
`define DPCD_REG_RWAIT  12'h008
`define DPCD_REG_CWAIT  12'h00c
`define DPCD_REG_STAT   12'h010

// ==========================================
// Control fields
`define DPCD_CTRL_ECC     0
`define DPCD_CTRL_MRANK   1
`define DPCD_CTRL_CPLX    2
`define DPCD_CTRL_RDVREF  3
`define DPCD_CTRL_JIT     4
`define DPCD_CTRL_W       5
`define DPCD_CTRL_RST     5'h14

// ==========================================
// Latency fields: CWL [4:0], CL [9:5], AL [11:10]
`define DPCD_LAT_CWL_LSB  0
`define DPCD_LAT_CL_LSB   5
`define DPCD_LAT_AL_LSB   10
`define DPCD_LAT_W        12
`define DPCD_LAT_RST      12'h169

// ==========================================
// Wait counts in system clocks
`define DPCD_CNT_W        18
`define DPCD_RWAIT_RST    18'h0d039
`define DPCD_CWAIT_RST    18'h2088f
`define DPCD_CNT_MAX      18'h3ffff

`endif

// ---- dpcd_top.sv ----
// Command delay and startup sequencing block with APB registers
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dpcd_regs.svh"
module dpcd_top #(
   parameter int                  CMD_W       = 32,
   parameter int                  SCHED_DEPTH = 64,
   parameter bit                  SIM_BUILD   = 1'b0,
   parameter dpcd_pkg::dpcd_cnt_t RWAIT_DFLT  = `DPCD_RWAIT_RST,
   parameter dpcd_pkg::dpcd_cnt_t CWAIT_DFLT  = `DPCD_CWAIT_RST
) (
   // Clock, reset and clock enable
   input  wire logic               CORE_CLK,
   input  wire logic               RST,
   input  wire logic               CE,
   // APB slave
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [11:0]        PADDR,
   input  wire logic [31:0]        PWDATA,
   input  wire logic [3:0]         PSTRB,
   output logic [31:0]             PRDATA,
   output logic                    PREADY,
   output logic                    PSLVERR,
   // Startup sequencing
   input  wire logic               CAL_DONE,
   output logic                    DRAM_RESET_N,
   output logic                    DRAM_CKE,
   // Command/address path
   input  wire logic [CMD_W-1:0]   CMD_ADDR_IN,
   input  wire logic               CMD_VALID_IN,
   output logic [CMD_W-1:0]        CMD_ADDR_OUT,
   output logic                    CMD_VALID_OUT,
   // Column requests and derived controls
   input  wire logic               WRITE_COLUMN_REQUEST,
   input  wire logic               READ_COLUMN_REQUEST,
   output logic                    WRITE_DATA_WINDOW_ENABLE,
   output logic                    READ_CAPTURE_ENABLE,
   output dpcd_pkg::dpcd_lat_t     ADDED_CMD_LATENCY,
   // Calibration stage selection
   output logic                    CAL_COMPLEX_RUN,
   output logic                    CAL_RD_VREF_RUN,
   output logic                    CAL_WR_DQS_DQ_RUN,
   output logic                    JITTER_CAL_FLAG
);
   import dpcd_pkg::*;

   localparam int IW = $clog2(SCHED_DEPTH);
   localparam logic [6:0] TAP_MAX = 7'(SCHED_DEPTH - 1);

   // ==========================================
   // Registers and state
   logic [`DPCD_CTRL_W-1:0] ctrl_ff;
   logic [`DPCD_LAT_W-1:0]  lat_cfg_ff;
   dpcd_cnt_t               rwait_ff, cwait_ff;
   dpcd_lat_t               lat_ff;
   dpcd_init_e              state_ff, nxt_state;
   logic                    reset_n_ff, cke_ff;
   logic                    pready_ff, pslverr_ff;
   logic [31:0]             prdata_ff;
   logic [SCHED_DEPTH-1:0]  wr_sh_ff, rd_sh_ff;
   logic                    wdwe_ff, rce_ff;
   logic                    cplx_ff, rdvref_ff, wrdq_ff, jit_ff;
   logic                    r_done, c_done;

   // ==========================================
   // APB decode
   wire hit_ctrl  = (PADDR == `DPCD_REG_CTRL);
   wire hit_lat   = (PADDR == `DPCD_REG_LAT);
   wire hit_rwait = (PADDR == `DPCD_REG_RWAIT);
   wire hit_cwait = (PADDR == `DPCD_REG_CWAIT);
   wire hit_stat  = (PADDR == `DPCD_REG_STAT);
   wire hit_any   = hit_ctrl | hit_lat | hit_rwait | hit_cwait | hit_stat;
   wire access    = PSEL & PENABLE;
   wire commit    = access & pready_ff;
   wire wr_go     = commit & PWRITE & hit_any;
   wire [31:0] bmask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};

   // Byte-lane merge of write data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   // Read mux
   wire [31:0] stat_w = {26'h0, cke_ff, reset_n_ff, state_ff, lat_ff};
   wire [31:0] rd_mux = hit_ctrl  ? {27'h0, ctrl_ff} :
                        hit_lat   ? {20'h0, lat_cfg_ff} :
                        hit_rwait ? {14'h0, rwait_ff} :
                        hit_cwait ? {14'h0, cwait_ff} :
                        hit_stat  ? stat_w : 32'h0;

   // Write data merged per register
   wire [31:0] ctrl_m  = merge({27'h0, ctrl_ff}, PWDATA, bmask);
   wire [31:0] lat_m   = merge({20'h0, lat_cfg_ff}, PWDATA, bmask);
   wire [31:0] rwait_m = merge({14'h0, rwait_ff}, PWDATA, bmask);
   wire [31:0] cwait_m = merge({14'h0, cwait_ff}, PWDATA, bmask);

   // APB handshake: one wait state, then the answer
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else if (CE) begin
         pready_ff  <= access & ~pready_ff;
         pslverr_ff <= access & ~pready_ff & ~hit_any;
         prdata_ff  <= (access & ~pready_ff & ~PWRITE) ? rd_mux : 32'h0;
      end
   end

   // Software registers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_ff    <= `DPCD_CTRL_RST;
         lat_cfg_ff <= `DPCD_LAT_RST;
         rwait_ff   <= RWAIT_DFLT;
         cwait_ff   <= CWAIT_DFLT;
      end else if (CE && wr_go) begin
         if (hit_ctrl) begin
            ctrl_ff <= ctrl_m[`DPCD_CTRL_W-1:0];
         end else if (hit_lat) begin
            lat_cfg_ff <= lat_m[`DPCD_LAT_W-1:0];
         end else if (hit_rwait) begin
            rwait_ff <= rwait_m[`DPCD_CNT_W-1:0];
         end else if (hit_cwait) begin
            cwait_ff <= cwait_m[`DPCD_CNT_W-1:0];
         end
      end
   end

   // ==========================================
   // Added command latency selection
   wire [4:0] cwl = lat_cfg_ff[`DPCD_LAT_CWL_LSB +: 5];
   wire [4:0] cl  = lat_cfg_ff[`DPCD_LAT_CL_LSB +: 5];
   wire [1:0] al  = lat_cfg_ff[`DPCD_LAT_AL_LSB +: 2];
   wire       big = ctrl_ff[`DPCD_CTRL_ECC] | ctrl_ff[`DPCD_CTRL_MRANK];

   // Required latency per CWL, CL, AL and rank/ECC column
   function automatic dpcd_lat_t lat_calc(input logic [4:0] w, input logic [4:0] c,
                                          input logic [1:0] a, input logic b);
      dpcd_lat_t lo;
      dpcd_lat_t hi;
      lo = 2'd0;
      hi = 2'd0;
      if (a == 2'd0) begin
         if (w <= 5'd8) begin
            lo = 2'd1;
            hi = 2'd2;
         end else if (w <= 5'd12) begin
            hi = 2'd1;
         end
      end else if (w == 5'd5) begin
         if (c == 5'd5 && a != 2'd1) begin
            lo = 2'd1;
            hi = 2'd2;
         end else begin
            hi = 2'd1;
         end
      end else if (w == 5'd6) begin
         if (!(c >= 5'd8 && a == 2'd1)) begin
            hi = 2'd1;
         end
      end else if (w == 5'd7) begin
         if (c == 5'd7 && a != 2'd1) begin
            hi = 2'd1;
         end
      end
      lat_calc = b ? hi : lo;
   endfunction

   wire dpcd_lat_t req_lat = lat_calc(cwl, cl, al, big);

   // Latency register feeding the command path and scheduler
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         lat_ff <= 2'd0;
      end else if (CE) begin
         lat_ff <= req_lat;
      end
   end

   // ==========================================
   // Command/address path delay
   dpcd_cmd_pipe #(.W(CMD_W)) u_pipe (
      .clk   (CORE_CLK),
      .rst   (RST),
      .ce    (CE),
      .lat   (lat_ff),
      .cmd_i (CMD_ADDR_IN),
      .vld_i (CMD_VALID_IN),
      .cmd_o (CMD_ADDR_OUT),
      .vld_o (CMD_VALID_OUT)
   );

   // ==========================================
   // Control scheduling from undelayed column requests
   wire [4:0] al_cyc = (al == 2'd1) ? cl - 5'd1 : (al == 2'd2) ? cl - 5'd2 : 5'd0;
   wire [6:0] wr_sum = {2'b0, cwl} + {2'b0, al_cyc} + {5'b0, lat_ff};
   wire [6:0] rd_sum = {2'b0, cl} + {2'b0, al_cyc} + {5'b0, lat_ff};
   wire [6:0] wr_clp = (wr_sum > TAP_MAX) ? TAP_MAX : (wr_sum < 7'd2) ? 7'd2 : wr_sum;
   wire [6:0] rd_clp = (rd_sum > TAP_MAX) ? TAP_MAX : (rd_sum < 7'd2) ? 7'd2 : rd_sum;
   wire [IW-1:0] wr_tap = IW'(wr_clp - 7'd2);
   wire [IW-1:0] rd_tap = IW'(rd_clp - 7'd2);

   // Request history shifts and tapped controls
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         wr_sh_ff <= '0;
         rd_sh_ff <= '0;
         wdwe_ff  <= 1'b0;
         rce_ff   <= 1'b0;
      end else if (CE) begin
         wr_sh_ff <= {wr_sh_ff[SCHED_DEPTH-2:0], WRITE_COLUMN_REQUEST};
         rd_sh_ff <= {rd_sh_ff[SCHED_DEPTH-2:0], READ_COLUMN_REQUEST};
         wdwe_ff  <= wr_sh_ff[wr_tap];
         rce_ff   <= rd_sh_ff[rd_tap];
      end
   end

   // ==========================================
   // Startup sequence
   wire r_start = CE && (state_ff == DPCD_S_CAL) && CAL_DONE;
   wire c_start = CE && (state_ff == DPCD_S_RWAIT) && r_done;

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DPCD_S_CAL: begin
            if (CAL_DONE) nxt_state = DPCD_S_RWAIT;
         end
         DPCD_S_RWAIT: begin
            if (r_done) nxt_state = DPCD_S_CWAIT;
         end
         DPCD_S_CWAIT: begin
            if (c_done) nxt_state = DPCD_S_RUN;
         end
         default: begin
            nxt_state = DPCD_S_RUN;
         end
      endcase
   end

   // Sequencer and DRAM pin flops
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_ff   <= DPCD_S_CAL;
         reset_n_ff <= 1'b0;
         cke_ff     <= 1'b0;
      end else if (CE) begin
         state_ff   <= nxt_state;
         reset_n_ff <= reset_n_ff | (state_ff == DPCD_S_RWAIT && r_done);
         cke_ff     <= cke_ff | (state_ff == DPCD_S_CWAIT && c_done);
      end
   end

   dpcd_wait_ctr #(.W(`DPCD_CNT_W)) u_rwait (
      .clk   (CORE_CLK),
      .rst   (RST),
      .ce    (CE),
      .start (r_start),
      .limit (rwait_ff),
      .done  (r_done),
      .busy  ()
   );

   dpcd_wait_ctr #(.W(`DPCD_CNT_W)) u_cwait (
      .clk   (CORE_CLK),
      .rst   (RST),
      .ce    (CE),
      .start (c_start),
      .limit (cwait_ff),
      .done  (c_done),
      .busy  ()
   );

   // ==========================================
   // Calibration stage selection
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cplx_ff   <= 1'b1;
         rdvref_ff <= 1'b0;
         wrdq_ff   <= 1'b1;
         jit_ff    <= 1'b1;
      end else if (CE) begin
         cplx_ff   <= ctrl_ff[`DPCD_CTRL_CPLX];
         rdvref_ff <= ctrl_ff[`DPCD_CTRL_RDVREF];
         wrdq_ff   <= 1'b1;
         jit_ff    <= SIM_BUILD ? ctrl_ff[`DPCD_CTRL_JIT] : 1'b1;
      end
   end

   // Output assignments, all from flops
   assign PRDATA                   = prdata_ff;
   assign PREADY                   = pready_ff;
   assign PSLVERR                  = pslverr_ff;
   assign DRAM_RESET_N             = reset_n_ff;
   assign DRAM_CKE                 = cke_ff;
   assign WRITE_DATA_WINDOW_ENABLE = wdwe_ff;
   assign READ_CAPTURE_ENABLE      = rce_ff;
   assign ADDED_CMD_LATENCY        = lat_ff;
   assign CAL_COMPLEX_RUN          = cplx_ff;
   assign CAL_RD_VREF_RUN          = rdvref_ff;
   assign CAL_WR_DQS_DQ_RUN        = wrdq_ff;
   assign JITTER_CAL_FLAG          = jit_ff;

   // ==========================================
   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence reset_released;
      $rose(reset_n_ff);
   endsequence
   reset_after_wait_a: assert property (reset_released |-> $past(r_done))
      else $error("DRAM reset released without the reset wait");
   cke_after_reset_a: assert property ($rose(cke_ff) |-> reset_n_ff && $past(c_done))
      else $error("clock enable raised out of order");
   lat_range_a: assert property (lat_ff <= 2'd2)
      else $error("added latency above two");
   col_undelayed_a: assert property (CE && WRITE_COLUMN_REQUEST |=> wr_sh_ff[0])
      else $error("write column request delayed");
   sched_shift_a: assert property (CE && !$past(CE) == 1'b0 && $changed(lat_ff) && CE
                                   |-> wr_sum == $past(wr_sum) + lat_ff - $past(lat_ff))
      else $error("scheduling ignores added latency");
   low_cwl_sel_a: assert property (CE && al == 2'd0 && cwl >= 5'd5 && cwl <= 5'd7
                                   |=> lat_ff == ($past(big) ? 2'd2 : 2'd1))
      else $error("wrong added latency for low CWL");
   complex_flag_a: assert property (CE |=> cplx_ff == $past(ctrl_ff[`DPCD_CTRL_CPLX]))
      else $error("complex stage does not follow its flag");
   rdvref_flag_a: assert property (CE && !ctrl_ff[`DPCD_CTRL_RDVREF] |=> !rdvref_ff)
      else $error("read vref stage runs while skipped");
   wrdq_full_a: assert property (CAL_WR_DQS_DQ_RUN)
      else $error("write strobe stage not full");
   jitter_hw_a: assert property (!SIM_BUILD |-> JITTER_CAL_FLAG)
      else $error("jitter stage reduced in hardware build");
endmodule
`default_nettype wire

// ---- dpcd_wait_ctr.sv ----
// Startup wait counter: pulses done for one clock, the programmed number plus one clocks after start
`timescale 1ns/1ps
`default_nettype none
module dpcd_wait_ctr #(
   parameter int W = 18
) (
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Count request
   input  wire logic         start,
   input  wire logic [W-1:0] limit,
   // Result
   output logic              done,
   output logic              busy
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         busy_ff;
   logic         nxt_busy;
   logic         done_ff;
   logic         nxt_done;

   // ==========================================
   // Next state
   wire at_limit = (cnt_ff == limit);
   assign nxt_cnt  = start ? '0 : (busy_ff && !at_limit) ? cnt_ff + 1'b1 : cnt_ff;
   assign nxt_busy = start | (busy_ff & ~at_limit);
   assign nxt_done = busy_ff & at_limit & ~start;

   // Counter flops, cleared by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (ce) begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   assign done = done_ff;
   assign busy = busy_ff;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   done_at_limit_a: assert property (done |-> $past(cnt_ff) == $past(limit))
      else $error("wait counter finished before its limit");
   ctr_reset_clear_a: assert property (disable iff (1'b0) rst |=> cnt_ff == '0 && !busy_ff)
      else $error("wait counter not cleared by reset");
endmodule
`default_nettype wire

// ---- tb_dram_phy_cmd_delay_init.sv ----
// Self-checking bench for the command delay and startup block
`timescale 1ns/1ps
`default_nettype none
module tb_dram_phy_cmd_delay_init;
   import dpcd_pkg::*;
   localparam int RW = 20;
   localparam int CW = 30;
   logic        core_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cmd_in, cmd_out;
   logic        cal_done, dram_reset_n, dram_cke, vld_in, vld_out, wcr, rcr, wde, rce;
   logic        cplx, rdvref, wrdq, jit;
   dpcd_lat_t   lat;
   int          n_errors, checked;
   wire [4:0]   mon = {rce, wde, vld_out, dram_cke, dram_reset_n};

   dpcd_top #(.RWAIT_DFLT(18'(RW)), .CWAIT_DFLT(18'(CW))) i_dpcd_top (
      .CORE_CLK(core_clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .CAL_DONE(cal_done),
      .DRAM_RESET_N(dram_reset_n), .DRAM_CKE(dram_cke), .CMD_ADDR_IN(cmd_in),
      .CMD_VALID_IN(vld_in), .CMD_ADDR_OUT(cmd_out), .CMD_VALID_OUT(vld_out),
      .WRITE_COLUMN_REQUEST(wcr), .READ_COLUMN_REQUEST(rcr),
      .WRITE_DATA_WINDOW_ENABLE(wde), .READ_CAPTURE_ENABLE(rce),
      .ADDED_CMD_LATENCY(lat), .CAL_COMPLEX_RUN(cplx), .CAL_RD_VREF_RUN(rdvref),
      .CAL_WR_DQS_DQ_RUN(wrdq), .JITTER_CAL_FLAG(jit));
   dpcd_ctrl_model i_dpcd_ctrl_model (.clk(core_clk), .cmd(cmd_in), .vld(vld_in),
      .wr(wcr), .rd(rcr));

   // Compare and tally
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // APB transfer: hold the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int i;
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      if (i == 20) begin
         n_errors++;
         end_sim();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Cycles until a watched output goes high, counted from the current cycle
   task automatic measure(input int sel, output int n);
      for (n = 0; n < 200; n++) begin
         if (mon[sel] === 1'b1) break;
         @(posedge core_clk);
         #1;
      end
      if (n == 200) begin
         n_errors++;
         end_sim();
      end
   endtask

   task automatic t_reset();
      logic [31:0] q;
      logic        e;
      chk("reset_n", 32'(dram_reset_n), 0);
      chk("cke", 32'(dram_cke), 0);
      chk("flags", 32'({cplx, rdvref, wrdq, jit}), 32'hb);
      apb(1'b0, 12'h004, 0, q, e);
      chk("lat_reg", q, 32'h169);
      apb(1'b0, 12'h008, 0, q, e);
      chk("rwait_reg", q, RW);
      apb(1'b0, 12'h00c, 0, q, e);
      chk("cwait_reg", q, CW);
      apb(1'b1, 12'h020, 32'hffffffff, q, e);
      chk("bad_err", 32'(e), 1);
      apb(1'b0, 12'h020, 0, q, e);
      chk("bad_data", q, 0);
      $display("test reset done");
   endtask

   task automatic t_startup(input int lim);
      int          n;
      logic [31:0] q;
      logic        e;
      @(posedge core_clk);
      cal_done <= 1'b1;
      @(posedge core_clk);
      #1;
      // Counted from the edge that first samples CAL_DONE high
      measure(0, n);
      chk("rwait_cycles", n, lim + 2);
      measure(1, n);
      chk("cwait_cycles", n, CW + 2);
      apb(1'b0, 12'h010, 0, q, e);
      chk("stat_run", q, 32'h3c);
      $display("test startup done");
   endtask

   // Reset in mid-count after a frozen stretch, then a shorter programmed count
   task automatic t_restart();
      logic [31:0] q;
      logic        e;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0; // CAL_DONE still high, so the reset wait starts at once
      repeat (RW / 2) @(posedge core_clk);
      ce <= 1'b0;
      repeat (RW) @(posedge core_clk);
      chk("frozen_rn", 32'(dram_reset_n), 0);
      ce       <= 1'b1;
      rst      <= 1'b1;
      cal_done <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk("restart_rn", 32'(dram_reset_n), 0);
      apb(1'b1, 12'h008, 32'h5, q, e);
      t_startup(5);
      $display("test restart done");
   endtask

   // Added latency chosen from the configuration table
   task automatic t_lat();
      logic [15:0] tbl [8] = '{
         {5'd5, 5'd5, 2'd0, 2'd1, 2'd2}, {5'd5, 5'd5, 2'd1, 2'd0, 2'd1},
         {5'd5, 5'd5, 2'd2, 2'd1, 2'd2}, {5'd6, 5'd8, 2'd1, 2'd0, 2'd0},
         {5'd7, 5'd10, 2'd3, 2'd0, 2'd0}, {5'd8, 5'd11, 2'd0, 2'd1, 2'd2},
         {5'd12, 5'd9, 2'd0, 2'd0, 2'd1}, {5'd13, 5'd13, 2'd2, 2'd0, 2'd0}};
      logic [31:0] q;
      logic        e;
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, 12'h004, {20'h0, tbl[k][5:4], tbl[k][10:6], tbl[k][15:11]}, q, e);
         for (int m = 0; m < 3; m++) begin
            apb(1'b1, 12'h000, 32'h8 | (m == 0 ? 0 : m), q, e);
            repeat (2) @(posedge core_clk);
            #1;
            chk("added_lat", 32'(lat), m == 0 ? tbl[k][3:2] : tbl[k][1:0]);
            chk("flags", 32'({cplx, rdvref, wrdq, jit}), 32'h7);
         end
      end
      $display("test latency table done");
   endtask

   // Command path delay and undelayed column requests
   task automatic t_cmd();
      logic [31:0] q;
      logic        e;
      int          n;
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, 12'h004, k == 0 ? 32'h169 : 32'ha5, q, e);
         apb(1'b1, 12'h000, 32'h4 | (k == 2), q, e);
         repeat (2) @(posedge core_clk);
         i_dpcd_ctrl_model.issue(32'h5a000000 + k, 1'b1, 1'b0, 1'b0);
         measure(2, n);
         chk("cmd_delay", n, k);
         chk("cmd_addr", cmd_out, 32'h5a000000 + k);
         i_dpcd_ctrl_model.issue(32'h0, 1'b0, 1'b1, 1'b0);
         measure(3, n);
         chk("wr_window", n, (k == 0 ? 9 : 5 + k) - 1);
         i_dpcd_ctrl_model.issue(32'h0, 1'b0, 1'b0, 1'b1);
         measure(4, n);
         chk("rd_capture", n, (k == 0 ? 11 : 5 + k) - 1);
      end
      $display("test command path done");
   endtask

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Main sequence
   initial begin
      rst      = 1'b1;
      ce       = 1'b1;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h0;
      pwdata   = 32'h0;
      cal_done = 1'b0;
      n_errors = 0;
      checked  = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_startup(RW);
      t_restart();
      t_lat();
      t_cmd();
      end_sim();
   end
endmodule
`default_nettype wire
